// File: hw/hold_qualifier.sv
// qualifies a continuous high hold on one input
module hold_qualifier #(
   parameter int unsigned HOLD_CYCLES = sensor_io_pkg::HOLD_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic level,
   output logic      reached,
   output logic      released
);

   logic [31:0] count_reg;
   logic        qualified_reg;

   // a drop to low before the threshold only clears the count
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= 32'h0000_0000;
      end else if (!level) begin
         count_reg <= 32'h0000_0000;
      end else if (count_reg < HOLD_CYCLES) begin
         count_reg <= count_reg + 32'h0000_0001;
      end
   end

   // one pulse on the cycle the hold reaches its full length
   assign reached = level && (count_reg == HOLD_CYCLES - 1);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         qualified_reg <= 1'b0;
      end else if (!level) begin
         qualified_reg <= 1'b0;
      end else if (reached) begin
         qualified_reg <= 1'b1;
      end
   end

   // fall after a qualified hold, one cycle wide
   assign released = qualified_reg && !level;

endmodule

// File: hw/sensor_io_pkg.sv
// shared constants for the sensor discrete i/o and status block
package sensor_io_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int unsigned CLOCK_HZ        = 100_000_000;
   localparam int unsigned HOLD_TIME_MS    = 2000;
   localparam int unsigned SYNC_PULSE_US   = 1000;
   localparam int unsigned SCAN_PERIOD_US  = 20000;
   localparam int unsigned BLINK_HALF_MS   = 250;
   localparam int unsigned HOLD_CYCLES     = HOLD_TIME_MS * (CLOCK_HZ / 1000);
   localparam int unsigned PULSE_CYCLES    =
      SYNC_PULSE_US * (CLOCK_HZ / 1_000_000);
   localparam int unsigned SCAN_CYCLES     =
      SCAN_PERIOD_US * (CLOCK_HZ / 1_000_000);
   localparam int unsigned BLINK_CYCLES    = BLINK_HALF_MS * (CLOCK_HZ / 1000);

   // ************************************************************
   // register map (byte offsets)
   // ************************************************************
   localparam logic [4:0]  CTRL_OFFSET     = 5'h00;
   localparam logic [4:0]  STATUS_OFFSET   = 5'h04;
   localparam logic [4:0]  NET_ADDR_OFFSET = 5'h08;
   localparam logic [4:0]  TEMP_OFFSET     = 5'h0C;

   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK       = 32'h0000_01FF;
   localparam logic [31:0] NET_ADDR_RESET  = 32'hC0A8_000A;

   localparam int unsigned HEATER_EN_BIT   = 0;
   localparam int unsigned INVERT_BIT      = 1;
   localparam int unsigned BLUE_DET_BIT    = 2;
   localparam int unsigned SPEED_LSB       = 3;
   localparam int unsigned UNIT_LSB        = 5;
   localparam int unsigned PHASE_LSB       = 7;

   localparam int unsigned ST_STATE_LSB    = 0;
   localparam int unsigned ST_AREA_LSB     = 3;
   localparam int unsigned ST_HEATER_BIT   = 7;
   localparam int unsigned ST_RESTART_BIT  = 8;
   localparam int unsigned ST_ADDR_BIT     = 9;

   localparam logic signed [7:0] HEATER_ON_BELOW_C = 8'sh00;
   localparam logic signed [7:0] HEATER_OFF_ABOVE_C = 8'sh0A;

   localparam logic [1:0]  MASTER_UNIT     = 2'h0;

   typedef enum logic [2:0] {
      ST_START_UP,
      ST_OPERATE,
      ST_MALFUNCTION,
      ST_SLEEP,
      ST_ADDR_INIT
   } sensor_state_t;

endpackage

// File: hw/sensor_io_status_control.sv
// discrete i/o, lamps, heater and scan sync of the range sensor
// Operation
// - restart after restart input high two seconds
// - address reset: high two seconds, then low
// - address reset restores default network address
// - four area inputs select detection area
// - group of one master, three slaves
// - green always, red fault/blink, blue blinks except in operation and fault (off)
// - sync, contamination, malfunction outputs follow state
// - orange lamp lit while heater enabled
// - blue in operation: off or detection
// - detection polarity software invertible, default low
// - heater enable setting, reset disabled
// - heater on below zero degrees when enabled
// - heater off above ten degrees, hysteresis
// - one millisecond sync pulse per scan
// - master reference output runs in every state
module sensor_io_status_control #(
   parameter int unsigned HOLD_CYCLES  = sensor_io_pkg::HOLD_CYCLES,
   parameter int unsigned SCAN_CYCLES  = sensor_io_pkg::SCAN_CYCLES,
   parameter int unsigned PULSE_CYCLES = sensor_io_pkg::PULSE_CYCLES,
   parameter int unsigned BLINK_CYCLES = sensor_io_pkg::BLINK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        restart_in,
   input  wire logic        addr_reset_in,
   input  wire logic [3:0]  area_in,
   input  wire logic        sync_in,
   input  wire logic        boot_done,
   input  wire logic        fault_detected,
   input  wire logic        sleep_request,
   input  wire logic        contamination_detected,
   input  wire logic [2:0]  object_in_region,
   input  wire logic signed [7:0] temp_c,
   output logic [3:0]       area_select,
   output logic [31:0]      net_addr,
   output logic             restart_pulse,
   output logic             sync_out,
   output logic             ref_sync_out,
   output logic             contamination_out,
   output logic             malfunction_out,
   output logic [2:0]       detect_out,
   output logic             lamp_green,
   output logic             lamp_orange,
   output logic             lamp_blue,
   output logic             lamp_red,
   output logic             heater_drive
);

   // ************************************************************
   // declarations
   // ************************************************************
   sensor_io_pkg::sensor_state_t state_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] net_addr_reg;
   logic        ack_reg;
   logic [31:0] readdata_reg;
   logic        restart_reached;
   logic        addr_reached;
   logic        addr_released;
   logic        heater_on_reg;
   logic        sync_in_d_reg;
   logic [31:0] scan_cnt_reg;
   logic [31:0] ref_cnt_reg;
   logic [31:0] blink_cnt_reg;
   logic        blink_reg;
   logic [31:0] scan_len;
   logic [31:0] phase_offset;
   logic        is_master;
   logic        bus_write;

   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_value,
      input logic [31:0] new_value,
      input logic [3:0]  lanes
   );
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            result[i*8 +: 8] = new_value[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // ************************************************************
   // avalon slave: one wait cycle on every access
   // ************************************************************
   assign waitrequest = (read || write) && !ack_reg;
   assign bus_write   = write && ack_reg;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read || write) && !ack_reg;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         readdata_reg <= 32'h0000_0000;
      end else if (read && !ack_reg) begin
         case (address)
            sensor_io_pkg::CTRL_OFFSET: begin
               readdata_reg <= ctrl_reg;
            end
            sensor_io_pkg::STATUS_OFFSET: begin
               readdata_reg <= 32'h0000_0000;
               readdata_reg[sensor_io_pkg::ST_STATE_LSB +: 3] <= state_reg;
               readdata_reg[sensor_io_pkg::ST_AREA_LSB +: 4] <= area_select;
               readdata_reg[sensor_io_pkg::ST_HEATER_BIT] <= heater_on_reg;
               readdata_reg[sensor_io_pkg::ST_RESTART_BIT] <= restart_in;
               readdata_reg[sensor_io_pkg::ST_ADDR_BIT] <= addr_reset_in;
            end
            sensor_io_pkg::NET_ADDR_OFFSET: begin
               readdata_reg <= net_addr_reg;
            end
            sensor_io_pkg::TEMP_OFFSET: begin
               readdata_reg <= 32'($signed(temp_c));
            end
            default: begin
               readdata_reg <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign readdata = readdata_reg;

   // reset leaves the heater disabled and polarity at default
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= sensor_io_pkg::CTRL_RESET;
      end else if (bus_write && address == sensor_io_pkg::CTRL_OFFSET) begin
         ctrl_reg <= merge_bytes(ctrl_reg, writedata, byteenable)
                     & sensor_io_pkg::CTRL_MASK;
      end
   end

   // the restore wins over a software write in the same cycle
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         net_addr_reg <= sensor_io_pkg::NET_ADDR_RESET;
      end else if (addr_released) begin
         net_addr_reg <= sensor_io_pkg::NET_ADDR_RESET;
      end else if (bus_write
                   && address == sensor_io_pkg::NET_ADDR_OFFSET) begin
         net_addr_reg <= merge_bytes(net_addr_reg, writedata, byteenable);
      end
   end

   assign net_addr = net_addr_reg;

   // ************************************************************
   // hold qualification of restart and address reset
   // ************************************************************
   hold_qualifier #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) restart_hold (
      .clock    (clock),
      .rst_b    (rst_b),
      .level    (restart_in),
      .reached  (restart_reached),
      .released ()
   );

   hold_qualifier #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) addr_hold (
      .clock    (clock),
      .rst_b    (rst_b),
      .level    (addr_reset_in),
      .reached  (addr_reached),
      .released (addr_released)
   );

   // ************************************************************
   // sensor state
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= sensor_io_pkg::ST_START_UP;
      end else if (restart_reached) begin
         state_reg <= sensor_io_pkg::ST_START_UP;
      end else if (addr_reached) begin
         state_reg <= sensor_io_pkg::ST_ADDR_INIT;
      end else begin
         case (state_reg)
            sensor_io_pkg::ST_START_UP: begin
               if (fault_detected) begin
                  state_reg <= sensor_io_pkg::ST_MALFUNCTION;
               end else if (boot_done) begin
                  state_reg <= sensor_io_pkg::ST_OPERATE;
               end
            end
            sensor_io_pkg::ST_OPERATE: begin
               if (fault_detected) begin
                  state_reg <= sensor_io_pkg::ST_MALFUNCTION;
               end else if (sleep_request) begin
                  state_reg <= sensor_io_pkg::ST_SLEEP;
               end
            end
            sensor_io_pkg::ST_SLEEP: begin
               if (fault_detected) begin
                  state_reg <= sensor_io_pkg::ST_MALFUNCTION;
               end else if (!sleep_request) begin
                  state_reg <= sensor_io_pkg::ST_OPERATE;
               end
            end
            sensor_io_pkg::ST_ADDR_INIT: begin
               // new address takes effect through a fresh start-up
               if (addr_released) begin
                  state_reg <= sensor_io_pkg::ST_START_UP;
               end
            end
            sensor_io_pkg::ST_MALFUNCTION: begin
               state_reg <= sensor_io_pkg::ST_MALFUNCTION;
            end
            default: begin
               state_reg <= sensor_io_pkg::ST_START_UP;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         restart_pulse <= 1'b0;
      end else begin
         restart_pulse <= restart_reached;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         area_select <= 4'h0;
      end else begin
         area_select <= area_in;
      end
   end

   // ************************************************************
   // heater thermostat
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         heater_on_reg <= 1'b0;
      end else if (!ctrl_reg[sensor_io_pkg::HEATER_EN_BIT]) begin
         heater_on_reg <= 1'b0;
      end else if (temp_c < sensor_io_pkg::HEATER_ON_BELOW_C) begin
         heater_on_reg <= 1'b1;
      end else if (temp_c > sensor_io_pkg::HEATER_OFF_ABOVE_C) begin
         heater_on_reg <= 1'b0;
      end
   end

   assign heater_drive = heater_on_reg;

   // ************************************************************
   // scan timing and group synchronisation
   // ************************************************************
   // speed 0: base scan, 1: twice as long, 2 or 3: four times
   assign scan_len = (ctrl_reg[sensor_io_pkg::SPEED_LSB +: 2] == 2'h0)
                     ? SCAN_CYCLES
                     : (ctrl_reg[sensor_io_pkg::SPEED_LSB +: 2] == 2'h1)
                     ? 32'(SCAN_CYCLES << 1) : 32'(SCAN_CYCLES << 2);
   assign phase_offset = 32'((scan_len >> 2)
                         * ctrl_reg[sensor_io_pkg::PHASE_LSB +: 2]);
   // unit index 0 is the one master, 1 to 3 are slaves
   assign is_master = ctrl_reg[sensor_io_pkg::UNIT_LSB +: 2]
                      == sensor_io_pkg::MASTER_UNIT;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sync_in_d_reg <= 1'b0;
      end else begin
         sync_in_d_reg <= sync_in;
      end
   end

   // every unit, master too, realigns its scan on the reference edge
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scan_cnt_reg <= 32'h0000_0000;
      end else if (sync_in && !sync_in_d_reg) begin
         scan_cnt_reg <= phase_offset;
      end else if (scan_cnt_reg >= scan_len - 1) begin
         scan_cnt_reg <= 32'h0000_0000;
      end else begin
         scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
      end
   end

   // free running, so faults and restarts never stop the reference
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ref_cnt_reg <= 32'h0000_0000;
      end else if (ref_cnt_reg >= scan_len - 1) begin
         ref_cnt_reg <= 32'h0000_0000;
      end else begin
         ref_cnt_reg <= ref_cnt_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= 1'b0;
      end else if (blink_cnt_reg >= BLINK_CYCLES - 1) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= !blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end

   // ************************************************************
   // output and lamp drive by state
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ref_sync_out <= 1'b0;
      end else begin
         ref_sync_out <= is_master && (ref_cnt_reg < (scan_len >> 1));
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sync_out          <= 1'b1;
         contamination_out <= 1'b1;
         malfunction_out   <= 1'b1;
      end else begin
         case (state_reg)
            sensor_io_pkg::ST_OPERATE: begin
               sync_out          <= scan_cnt_reg < PULSE_CYCLES;
               contamination_out <= contamination_detected;
               malfunction_out   <= 1'b1;
            end
            sensor_io_pkg::ST_MALFUNCTION,
            sensor_io_pkg::ST_ADDR_INIT: begin
               sync_out          <= 1'b1;
               contamination_out <= 1'b0;
               malfunction_out   <= 1'b0;
            end
            sensor_io_pkg::ST_SLEEP: begin
               sync_out          <= 1'b1;
               contamination_out <= 1'b0;
               malfunction_out   <= 1'b1;
            end
            default: begin
               sync_out          <= 1'b1;
               contamination_out <= 1'b1;
               malfunction_out   <= 1'b1;
            end
         endcase
      end
   end

   // default: a region with an object drives its output low
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         detect_out <= 3'h7;
      end else begin
         detect_out <= ~object_in_region
                       ^ {3{ctrl_reg[sensor_io_pkg::INVERT_BIT]}};
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lamp_green  <= 1'b1;
         lamp_orange <= 1'b0;
         lamp_blue   <= 1'b0;
         lamp_red    <= 1'b0;
      end else begin
         lamp_green  <= 1'b1;
         lamp_orange <= ctrl_reg[sensor_io_pkg::HEATER_EN_BIT];
         case (state_reg)
            sensor_io_pkg::ST_OPERATE: begin
               lamp_blue <= ctrl_reg[sensor_io_pkg::BLUE_DET_BIT]
                            && (|object_in_region);
               lamp_red  <= 1'b0;
            end
            sensor_io_pkg::ST_MALFUNCTION: begin
               lamp_blue <= 1'b0;
               lamp_red  <= 1'b1;
            end
            sensor_io_pkg::ST_ADDR_INIT: begin
               lamp_blue <= blink_reg;
               lamp_red  <= blink_reg;
            end
            default: begin
               lamp_blue <= blink_reg;
               lamp_red  <= 1'b0;
            end
         endcase
      end
   end

endmodule

// File: verif/sio_checker.sv
// port relations checker for the sensor status block
module sio_checker #(
   parameter int unsigned HOLD_CYCLES = 20
) (
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic              read,
   input wire logic              write,
   input wire logic              waitrequest,
   input wire logic              restart_in,
   input wire logic              restart_pulse,
   input wire logic              addr_reset_in,
   input wire logic [31:0]       net_addr,
   input wire logic              sync_out,
   input wire logic              contamination_out,
   input wire logic              malfunction_out,
   input wire logic              lamp_green,
   input wire logic              lamp_orange,
   input wire logic              heater_drive,
   input wire logic signed [7:0] temp_c
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   logic [31:0] run_reg;
   logic        qual_reg;
   // ************************************************************
   // hold tracking
   // ************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         run_reg <= 32'h0;
      else
         run_reg <= restart_in ? run_reg + 32'h1 : 32'h0;
   end
   // cleared first on the pulse; set again the next cycle if the input is still held
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         qual_reg <= 1'b0;
      else if (restart_pulse)
         qual_reg <= 1'b0;
      else if (restart_in && run_reg >= HOLD_CYCLES - 1)
         qual_reg <= 1'b1;
   end
   // ************************************************************
   // assertions
   // ************************************************************
   a_green_lit: assert property (lamp_green)
      else $error("green lamp dark");
   a_restart_held: assert property (restart_pulse |-> qual_reg)
      else $error("restart without full hold");
   a_addr_restore: assert property (
      $changed(net_addr) && !$past(write)
      |-> net_addr == sensor_io_pkg::NET_ADDR_RESET && !$past(addr_reset_in))
      else $error("address changed wrongly");
   a_fault_outs: assert property (!malfunction_out
      |-> sync_out && !contamination_out)
      else $error("fault output set wrong");
   a_contam_malf: assert property (
      contamination_out |-> malfunction_out)
      else $error("contamination with fault");
   a_one_wait: assert property ($rose(read) || $rose(write)
      |-> waitrequest ##1 !waitrequest)
      else $error("bus wait not one cycle");
   a_heater_cold: assert property (lamp_orange && temp_c < 8'sh00
      |-> ##[1:2] heater_drive)
      else $error("heater not on when cold");
   a_heater_hot: assert property (temp_c > 8'sh0A
      |-> ##[1:2] !heater_drive)
      else $error("heater not off when warm");
   c_restart: cover property (restart_pulse);
   c_fault: cover property (!malfunction_out);
   c_heat: cover property (heater_drive);
endmodule

bind sensor_io_status_control sio_checker #(
   .HOLD_CYCLES(HOLD_CYCLES)
) u_sio_checker (.*);

// File: verif/sync_peer_model.sv
// sync line wiring with an optional foreign peer reference
module sync_peer_model #(
   parameter int unsigned PERIOD = 40
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ref_in,
   input wire logic peer_en,
   output logic     sync_line
);
   logic [15:0] cnt_reg;
   // peer runs at the same scan period as the unit
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b)
         cnt_reg <= 16'h0;
      else
         cnt_reg <= (cnt_reg == 16'(PERIOD - 1)) ? 16'h0 : cnt_reg + 16'h1;
   end
   // master reference looped back to its own input
   assign sync_line = peer_en ? (cnt_reg < 16'(PERIOD / 2)) : ref_in;
endmodule

// File: verif/tb_sensor_io_status_control.sv
// self-checking bench for the sensor status block
`define CHK(n, e, g) chk(n, 32'(e), 32'(g));
module tb_sensor_io_status_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned HOLD = 20;
   localparam int unsigned SCAN = 40;
   localparam int unsigned PULSE = 2;
   localparam int unsigned BLINK = 4;
   logic clock = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0;
   logic [4:0] address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, net_addr, q;
   logic [3:0] byteenable = 4'hF, area_in = 4'h0, area_select;
   logic restart_in = 1'b0, addr_reset_in = 1'b0, sync_in, boot_done = 1'b0;
   logic fault_detected = 1'b0, sleep_request = 1'b0, peer_en = 1'b0;
   logic contamination_detected = 1'b0, waitrequest, restart_pulse, r;
   logic [2:0] object_in_region = 3'h0, detect_out;
   logic signed [7:0] temp_c = 8'sh05;
   logic sync_out, ref_sync_out, contamination_out, malfunction_out;
   logic lamp_green, lamp_orange, lamp_blue, lamp_red, heater_drive;
   wire logic [2:0] out_trio = {sync_out, contamination_out, malfunction_out};
   int fail_count = 0, compares = 0, n, i;
   always #5 clock = ~clock;
   sensor_io_status_control #(.HOLD_CYCLES(HOLD), .SCAN_CYCLES(SCAN),
      .PULSE_CYCLES(PULSE), .BLINK_CYCLES(BLINK))
      u_sensor_io_status_control (.*);
   sync_peer_model #(.PERIOD(SCAN)) u_sync_peer_model (.clock(clock),
      .rst_b(rst_b), .ref_in(ref_sync_out), .peer_en(peer_en),
      .sync_line(sync_in));
   task automatic chk(input string s, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   // ************************************************************
   // bus master and helpers
   // ************************************************************
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      read <= !wr;
      write <= wr;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clock);
   endtask
   task automatic state_is(input logic [2:0] s);
      bus(1'b0, 5'h04, 32'h0);
      `CHK("state", s, q[2:0])
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      cyc(1);
      `CHK("outs", 3'b111, out_trio)
      bus(1'b0, 5'h00, 32'h0);
      `CHK("ctrl", 32'h0, q)
      bus(1'b0, 5'h08, 32'h0);
      `CHK("addr", sensor_io_pkg::NET_ADDR_RESET, q)
      bus(1'b0, 5'h10, 32'h0);
      `CHK("unmapped", 32'h0, q)
      for (i = 0; i < 16; i += 5) begin
         @(posedge clock);
         area_in <= 4'(i);
         bus(1'b0, 5'h04, 32'h0);
         `CHK("area", i, q[6:3])
         `CHK("area_sel", i, area_select)
      end
      @(posedge clock);
      boot_done <= 1'b1;
      object_in_region <= 3'b101;
      cyc(3);
      `CHK("op_outs", 2'b01, {contamination_out, malfunction_out})
      `CHK("detect", 3'b010, detect_out)
      `CHK("blue", 1'b0, lamp_blue)
      n = 0;
      repeat (SCAN) begin @(negedge clock); n += sync_out; end
      `CHK("pulse", PULSE, n)
      bus(1'b1, 5'h00, 32'h6);
      cyc(3);
      `CHK("inverted", 3'b101, detect_out)
      `CHK("blue_det", 1'b1, lamp_blue)
      @(posedge clock);
      contamination_detected <= 1'b1;
      temp_c <= 8'shFF;
      cyc(3);
      `CHK("contam", 1'b1, contamination_out)
      `CHK("heat_off", 1'b0, heater_drive)
      bus(1'b1, 5'h00, 32'h1);
      cyc(3);
      `CHK("orange", 1'b1, lamp_orange)
      `CHK("heat_on", 1'b1, heater_drive)
      bus(1'b0, 5'h0C, 32'h0);
      `CHK("temp", 32'hFFFF_FFFF, q)
      @(posedge clock);
      temp_c <= 8'sh05;
      cyc(3);
      `CHK("heat_hold", 1'b1, heater_drive)
      @(posedge clock);
      temp_c <= 8'sh0B;
      cyc(3);
      `CHK("heat_stop", 1'b0, heater_drive)
      @(posedge clock);
      sleep_request <= 1'b1;
      cyc(3);
      `CHK("sleep", 3'b101, out_trio)
      state_is(3'h3);
      @(posedge clock);
      sleep_request <= 1'b0;
      restart_in <= 1'b1;
      cyc(HOLD - 1);
      @(posedge clock);
      restart_in <= 1'b0;
      cyc(3);
      state_is(3'h1);
      @(posedge clock);
      fault_detected <= 1'b1;
      cyc(3);
      `CHK("fault", 3'b100, out_trio)
      `CHK("red", 1'b1, lamp_red)
      n = 0;
      repeat (SCAN) begin @(negedge clock); n += ref_sync_out; end
      `CHK("ref_run", SCAN / 2, n)
      bus(1'b1, 5'h00, 32'h9);
      cyc(2);
      n = 0;
      repeat (2 * SCAN) begin @(negedge clock); n += ref_sync_out; end
      `CHK("ref_slow", SCAN, n)
      @(posedge clock);
      fault_detected <= 1'b0;
      restart_in <= 1'b1;
      n = 0;
      repeat (HOLD + 4) begin @(negedge clock); n += restart_pulse; end
      `CHK("restart", 1, n)
      @(posedge clock);
      restart_in <= 1'b0;
      bus(1'b1, 5'h08, 32'h1234_5678);
      @(posedge clock);
      addr_reset_in <= 1'b1;
      cyc(HOLD + 2);
      state_is(3'h4);
      `CHK("addr_held", 32'h1234_5678, net_addr)
      r = lamp_red;
      n = 0;
      repeat (4 * BLINK) begin
         @(negedge clock);
         n += (lamp_red !== r);
         r = lamp_red;
      end
      `CHK("red_blink", 4, n)
      @(posedge clock);
      addr_reset_in <= 1'b0;
      cyc(3);
      `CHK("addr_back", sensor_io_pkg::NET_ADDR_RESET, net_addr)
      bus(1'b1, 5'h00, 32'h1A0);
      @(posedge clock);
      peer_en <= 1'b1;
      cyc(SCAN);
      n = 0;
      repeat (SCAN) begin @(negedge clock); n += ref_sync_out; end
      `CHK("slave_ref", 0, n)
      @(posedge sync_in);
      n = 0;
      while (sync_out !== 1'b1) begin @(negedge clock); n++; end
      `CHK("phase", SCAN / 4 + 3, n)
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      tally_and_finish;
   end
endmodule
